// ### rtl/adc_sample_sequence_timing.sv
/*
 * Start, sample/hold timing and result capture for a 12-bit pipelined
 * converter, in sequential and simultaneous sampling modes, with a small
 * register port and a level interrupt.
 * Assumes the block clock is the converter clock and that all inputs are
 * synchronous to it; the analog core holds each sample stable on coreSample
 * when the block captures it.
 */
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_sample_sequence_timing
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    input wire logic [1:0] eventManagerTriggers,
    input wire logic externalConversionStart,
    input wire adc_seq_pkg::core_sample_type coreSample,
    output logic sampleHold,
    output logic sampleStrobe,
    output adc_seq_pkg::chan_select_type sampleChannel,
    output logic busy,
    output logic interrupt
);

    import adc_seq_pkg::*;

    localparam logic [1:0] TRIG_WAIT = 2'(`TRIG_DELAY_CYC - 1);

    // ============================================================
    // Register state
    logic [15:0] ctrlOne;
    logic [15:0] ctrlTwo;
    logic [15:0] chanSel;
    logic [`STAT_WIDTH-1:0] status;
    logic [`STAT_WIDTH-1:0] mask;
    logic [11:0] resultA;
    logic [11:0] resultB;
    logic [15:0] next_ctrlOne;
    logic [15:0] next_ctrlTwo;
    logic [15:0] next_chanSel;
    logic [`STAT_WIDTH-1:0] next_status;
    logic [`STAT_WIDTH-1:0] next_mask;
    logic [11:0] next_resultA;
    logic [11:0] next_resultB;
    logic [15:0] next_regRdata;

    // ============================================================
    // Sequencer state
    seq_state_type state;
    seq_state_type next_state;
    settings_type held;
    settings_type next_held;
    logic [3:0] phaseCnt;
    logic [3:0] next_phaseCnt;
    logic [4:0] slotsLeft;
    logic [4:0] next_slotsLeft;
    logic [4:0] resultsLeft;
    logic [4:0] next_resultsLeft;
    logic extPrev;
    logic next_extPrev;

    // Events between the parts.
    logic swTrigger;
    logic stopReq;
    logic trigger;
    logic slotStart;
    logic strobeA;
    logic strobeB;
    logic finalResult;
    logic seqDone;
    logic [1:0] flagEvents;
    logic [1:0] flagLate;
    logic [`STAT_WIDTH-1:0] setBits;

    // ============================================================
    // Trigger sources; software pulses come from a one written to the
    // trigger bit and are never stored.
    assign swTrigger = regWrite && regAddr == `REG_CTRL_TWO
        && regWdata[`CTRL2_SWTRIG_BIT];
    assign stopReq = regWrite && regAddr == `REG_CTRL_TWO
        && regWdata[`CTRL2_STOP_BIT];
    assign trigger = swTrigger
        || (ctrlTwo[`CTRL2_EVEN_BIT] && |eventManagerTriggers)
        || (ctrlTwo[`CTRL2_EXTEN_BIT] && externalConversionStart
            && !extPrev);

    // A new slot opens on the first cycle of every sample/hold pulse.
    assign slotStart = state == ST_HOLD && phaseCnt == 4'h0;

    // ============================================================
    // Sequencer: trigger delay, hold pulse, gap, and the next slot.
    always_comb
    begin
        next_state = state;
        next_held = held;
        next_phaseCnt = phaseCnt;
        next_slotsLeft = slotsLeft;
        next_extPrev = externalConversionStart;
        sampleStrobe = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (trigger)
                begin
                    // Settings are frozen for the whole sequence.
                    next_held.simultaneous = ctrlOne[`CTRL1_MODE_BIT];
                    next_held.continuous = ctrlOne[`CTRL1_CONT_BIT];
                    next_held.acq = ctrlOne[`CTRL1_ACQ_HI:`CTRL1_ACQ_LO];
                    next_held.len = ctrlOne[`CTRL1_LEN_HI:`CTRL1_LEN_LO];
                    next_slotsLeft = {1'b0,
                        ctrlOne[`CTRL1_LEN_HI:`CTRL1_LEN_LO]};
                    next_phaseCnt = 4'h0;
                    next_state = ST_DELAY;
                end
            end
            ST_DELAY:
            begin
                // The half cycle rounds up to whole converter clocks.
                if (phaseCnt[1:0] == TRIG_WAIT)
                begin
                    next_phaseCnt = 4'h0;
                    next_state = ST_HOLD;
                end
                else
                begin
                    next_phaseCnt = phaseCnt + 4'h1;
                end
            end
            ST_HOLD:
            begin
                // Pulse lasts one plus the prescale, 1 to 16 clocks.
                if (phaseCnt == held.acq)
                begin
                    // Falling edge: the channel or both pair channels are
                    // sampled together here.
                    sampleStrobe = 1'b1;
                    next_phaseCnt = 4'h0;
                    next_state = ST_GAP;
                end
                else
                begin
                    next_phaseCnt = phaseCnt + 4'h1;
                end
            end
            ST_GAP:
            begin
                // The gap sets the slot period to 2 or 3 plus the prescale.
                if (phaseCnt == (held.simultaneous ?
                    4'(`GAP_SIM_CYC - 1) : 4'(`GAP_SEQ_CYC - 1)))
                begin
                    next_phaseCnt = 4'h0;
                    if (stopReq)
                    begin
                        next_state = ST_IDLE;
                    end
                    else if (slotsLeft != 5'h0)
                    begin
                        next_slotsLeft = slotsLeft - 5'h1;
                        next_state = ST_HOLD;
                    end
                    else if (held.continuous)
                    begin
                        next_slotsLeft = {1'b0, held.len};
                        next_state = ST_HOLD;
                    end
                    else
                    begin
                        next_state = ST_IDLE;
                    end
                end
                else
                begin
                    next_phaseCnt = phaseCnt + 4'h1;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            held <= '0;
            phaseCnt <= 4'h0;
            slotsLeft <= 5'h0;
            extPrev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            held <= next_held;
            phaseCnt <= next_phaseCnt;
            slotsLeft <= next_slotsLeft;
            extPrev <= next_extPrev;
        end
    end

    // ============================================================
    // Result latency from the start of each slot; the pipeline lets slots
    // overlap because each slot carries its own delayed strobe.
    pulse_delay #(.DEPTH(`RES_A_LAT_CYC - 1), .WIDTH(1)) delayA
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pulseIn(slotStart),
        .pulseOut(strobeA)
    );

    pulse_delay #(.DEPTH(`RES_B_LAT_CYC - 1), .WIDTH(1)) delayB
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pulseIn(slotStart && held.simultaneous),
        .pulseOut(strobeB)
    );

    // The last result of a slot is group A alone, or group B of a pair.
    assign finalResult = held.simultaneous ? strobeB : strobeA;
    assign seqDone = finalResult && resultsLeft == 5'h0;
    assign flagEvents = {seqDone, finalResult};

    // Flags trail the result register update by a fixed number of cycles.
    pulse_delay #(.DEPTH(`FLAG_DELAY_CYC), .WIDTH(2)) delayFlag
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pulseIn(flagEvents),
        .pulseOut(flagLate)
    );

    // ============================================================
    // Result capture and count of results still owed in a pass.
    always_comb
    begin
        next_resultA = resultA;
        next_resultB = resultB;
        next_resultsLeft = resultsLeft;
        if (strobeA)
        begin
            next_resultA = coreSample.groupA;
        end
        if (strobeB)
        begin
            next_resultB = coreSample.groupB;
        end
        if (state == ST_IDLE && trigger)
        begin
            next_resultsLeft = {1'b0, ctrlOne[`CTRL1_LEN_HI:`CTRL1_LEN_LO]};
        end
        else if (finalResult)
        begin
            next_resultsLeft = resultsLeft == 5'h0 ? {1'b0, held.len}
                : resultsLeft - 5'h1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            resultA <= 12'h000;
            resultB <= 12'h000;
            resultsLeft <= 5'h00;
        end
        else
        begin
            resultA <= next_resultA;
            resultB <= next_resultB;
            resultsLeft <= next_resultsLeft;
        end
    end

    // ============================================================
    // Register port, status flags and read data.
    always_comb
    begin
        next_ctrlOne = ctrlOne;
        next_ctrlTwo = ctrlTwo;
        next_chanSel = chanSel;
        next_mask = mask;
        setBits = '0;
        setBits[`STAT_RESULT_BIT] = flagLate[0];
        setBits[`STAT_DONE_BIT] = flagLate[1];
        setBits[`STAT_OVERRUN_BIT] = trigger && state != ST_IDLE;
        next_status = status;
        if (regWrite)
        begin
            case (regAddr)
                `REG_CTRL_ONE: next_ctrlOne = regWdata;
                `REG_CTRL_TWO: next_ctrlTwo = regWdata
                    & ~(16'h0001 << `CTRL2_SWTRIG_BIT)
                    & ~(16'h0001 << `CTRL2_STOP_BIT);
                `REG_CHSEL: next_chanSel = regWdata;
                `REG_STATUS: next_status = status
                    & ~regWdata[`STAT_WIDTH-1:0];
                `REG_MASK: next_mask = regWdata[`STAT_WIDTH-1:0];
                default: next_status = status;
            endcase
        end
        // A set in the same cycle as a clear keeps the flag.
        next_status = next_status | setBits;
        next_regRdata = 16'h0000;
        if (regRead)
        begin
            case (regAddr)
                `REG_CTRL_ONE: next_regRdata = ctrlOne;
                `REG_CTRL_TWO: next_regRdata = ctrlTwo;
                `REG_CHSEL: next_regRdata = chanSel;
                `REG_STATUS: next_regRdata = {13'h0000, status};
                `REG_MASK: next_regRdata = {13'h0000, mask};
                `REG_RESULT_A: next_regRdata = {4'h0, resultA};
                `REG_RESULT_B: next_regRdata = {4'h0, resultB};
                `REG_STATE: next_regRdata = {9'h000, slotsLeft, state};
                default: next_regRdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            ctrlOne <= `CTRL1_RESET;
            ctrlTwo <= `CTRL2_RESET;
            chanSel <= `CHSEL_RESET;
            status <= '0;
            mask <= `MASK_RESET;
            regRdata <= 16'h0000;
        end
        else
        begin
            ctrlOne <= next_ctrlOne;
            ctrlTwo <= next_ctrlTwo;
            chanSel <= next_chanSel;
            status <= next_status;
            mask <= next_mask;
            regRdata <= next_regRdata;
        end
    end

    // ============================================================
    // Outputs. A pair always uses the same index in both groups, so the
    // group B channel is derived from the group A index.
    assign sampleHold = state == ST_HOLD;
    assign sampleChannel.pair = held.simultaneous;
    assign sampleChannel.chanA = held.simultaneous ?
        {1'b0, chanSel[2:0]} : chanSel[3:0];
    assign sampleChannel.chanB = {1'b1, chanSel[2:0]};
    assign busy = state != ST_IDLE;
    assign interrupt = |(status & mask);

endmodule

// ### rtl/adc_seq_cfg.svh
/*
 * Constants of the converter sequence and timing block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes the converter clock and the block clock are one and the same.
 */
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ============================================================
// Register offsets
`define REG_CTRL_ONE 8'h00
`define REG_CTRL_TWO 8'h04
`define REG_CHSEL 8'h08
`define REG_STATUS 8'h0c
`define REG_MASK 8'h10
`define REG_RESULT_A 8'h14
`define REG_RESULT_B 8'h18
`define REG_STATE 8'h1c

// ============================================================
// Field positions
`define CTRL1_MODE_BIT 3
`define CTRL1_CONT_BIT 4
`define CTRL1_ACQ_LO 8
`define CTRL1_ACQ_HI 11
`define CTRL1_LEN_LO 12
`define CTRL1_LEN_HI 15
`define CTRL2_SWTRIG_BIT 0
`define CTRL2_EVEN_BIT 1
`define CTRL2_EXTEN_BIT 2
`define CTRL2_STOP_BIT 3
`define STAT_RESULT_BIT 0
`define STAT_DONE_BIT 1
`define STAT_OVERRUN_BIT 2
`define STAT_WIDTH 3

// ============================================================
// Reset values
`define CTRL1_RESET 16'h0000
`define CTRL2_RESET 16'h0000
`define CHSEL_RESET 16'h0000
`define MASK_RESET 3'h0

// ============================================================
// Timing: converter clock period and documented delays in picoseconds
`define CLK_PERIOD_PS 40000
`define TRIG_DELAY_PS 100000
`define RES_A_LAT_PS 160000
`define RES_B_LAT_PS 200000
`define TRIG_DELAY_CYC ((`TRIG_DELAY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RES_A_LAT_CYC ((`RES_A_LAT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RES_B_LAT_CYC ((`RES_B_LAT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define GAP_SEQ_CYC 1
`define GAP_SIM_CYC 2
`define FLAG_DELAY_CYC 2

`endif

// ### rtl/adc_seq_pkg.sv
/*
 * Types shared by the converter sequence and timing block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adc_seq_pkg;

    // ============================================================
    // Sequencer states
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_HOLD = 2'b10,
        ST_GAP = 2'b11
    } seq_state_type;

    // Settings caught at each trigger that starts a sequence from idle.
    typedef struct packed
    {
        logic simultaneous;
        logic continuous;
        logic [3:0] acq;
        logic [3:0] len;
    } settings_type;

    // Samples offered by the analog pipeline, one per input group.
    typedef struct packed
    {
        logic [11:0] groupA;
        logic [11:0] groupB;
    } core_sample_type;

    // Channel selection driven to the analog multiplexer.
    typedef struct packed
    {
        logic [3:0] chanA;
        logic [3:0] chanB;
        logic pair;
    } chan_select_type;

endpackage

// ### rtl/pulse_delay.sv
/*
 * Fixed delay line that carries a group of pulses a set number of cycles.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module pulse_delay #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 1
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pulseIn,
    output logic [WIDTH-1:0] pulseOut
);

    logic [WIDTH-1:0] stage [DEPTH];
    logic [WIDTH-1:0] next_stage [DEPTH];

    // ============================================================
    // Shift the pulses one stage per cycle.
    always_comb
    begin
        next_stage[0] = pulseIn;
        for (int i = 1; i < DEPTH; i++)
        begin
            next_stage[i] = stage[i-1];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            if (!rstn)
            begin
                stage[i] <= '0;
            end
            else
            begin
                stage[i] <= next_stage[i];
            end
        end
    end

    assign pulseOut = stage[DEPTH-1];

endmodule

// ### sim/adc_seq_monitor.sv
/*
 * Checker of sample/hold timing, pair selection and result read width.
 * Assumes it is bound to the converter control block and sees its ports.
 */
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_seq_monitor
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdata,
    input wire logic sampleHold,
    input wire logic sampleStrobe,
    input wire adc_seq_pkg::chan_select_type sampleChannel,
    input wire logic busy
);
    import adc_seq_pkg::*;
    // ==========
    // Helper state: control shadow, settings held per sequence, hold count.
    logic [15:0] ctrl, next_ctrl;
    logic [4:0] holdCount, next_holdCount;
    logic [3:0] acqHeld, next_acqHeld;
    logic modeHeld, next_modeHeld, busyLast, next_busyLast;
    logic swTrig;

    // A software start taken while the sequencer is idle.
    assign swTrig = regWrite && regAddr == `REG_CTRL_TWO
        && regWdata[`CTRL2_SWTRIG_BIT] && !busy;

    // Settings are caught as busy rises, so later writes cannot leak in.
    always_comb
    begin
        next_ctrl = ctrl;
        if (regWrite && regAddr == `REG_CTRL_ONE)
            next_ctrl = regWdata;
        next_busyLast = busy;
        next_acqHeld = acqHeld;
        next_modeHeld = modeHeld;
        if (busy && !busyLast)
        begin
            next_acqHeld = ctrl[`CTRL1_ACQ_HI:`CTRL1_ACQ_LO];
            next_modeHeld = ctrl[`CTRL1_MODE_BIT];
        end
        next_holdCount = sampleHold ? holdCount + 5'h01 : 5'h00;
    end

    // Registers of the helper state.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            ctrl <= 16'h0000;
            busyLast <= 1'h0;
            acqHeld <= 4'h0;
            modeHeld <= 1'h0;
            holdCount <= 5'h00;
        end
        else
        begin
            ctrl <= next_ctrl;
            busyLast <= next_busyLast;
            acqHeld <= next_acqHeld;
            modeHeld <= next_modeHeld;
            holdCount <= next_holdCount;
        end
    end

    default clocking mcb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_TRIG_DELAY: assert property (swTrig |-> ##1 !sampleHold
        ##1 !sampleHold ##1 !sampleHold ##1 sampleHold)
        else $error("late or early sampling");
    AST_STROBE_LAST: assert property (sampleStrobe |-> sampleHold
        ##1 !sampleHold) else $error("strobe not in last hold cycle");
    AST_STROBE_HOLD: assert property (sampleHold && !sampleStrobe
        |=> sampleHold) else $error("hold ended without strobe");
    AST_HOLD_WIDTH: assert property ($fell(sampleHold) |->
        holdCount == {1'h0, acqHeld} + 5'h01) else $error("hold width wrong");
    AST_GAP_SEQ: assert property ($fell(sampleHold) && !modeHeld
        |=> sampleHold || !busy) else $error("sequential slot period wrong");
    AST_GAP_SIM: assert property ($fell(sampleHold) && modeHeld |->
        ##1 !sampleHold ##1 (sampleHold || !busy))
        else $error("simultaneous slot period wrong");
    AST_PAIR_MODE: assert property (sampleHold |->
        sampleChannel.pair == modeHeld) else $error("pair flag wrong");
    AST_PAIR_MATCH: assert property (sampleHold && modeHeld |->
        sampleChannel.chanA == {1'h0, sampleChannel.chanB[2:0]}
        && sampleChannel.chanB[3]) else $error("pair channels differ");
    AST_RESULT_WIDTH: assert property ($past(regRead) &&
        ($past(regAddr) == `REG_RESULT_A || $past(regAddr) == `REG_RESULT_B)
        |-> regRdata[15:12] == 4'h0) else $error("result wider than 12");
endmodule

bind adc_sample_sequence_timing adc_seq_monitor u_adc_seq_monitor
(
    .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .sampleHold(sampleHold),
    .sampleStrobe(sampleStrobe), .sampleChannel(sampleChannel),
    .busy(busy)
);

// ### sim/adc_core_model.sv
/*
 * Behavioural analog pipeline: offers a time-stamp sample every cycle.
 * Assumes the block captures coreSample on the rising clock edge.
 */
`timescale 1ns/1ps

module adc_core_model
(
    input wire logic ref_clk,
    output adc_seq_pkg::core_sample_type coreSample
);
    import adc_seq_pkg::*;
    // ==========
    // Each cycle gives a new 12-bit code, so a capture shows its own cycle.
    logic [11:0] stamp = 12'h000;

    always @(posedge ref_clk)
        stamp <= stamp + 12'h001;

    // Group B carries the inverse so the two groups never look alike.
    assign coreSample = {stamp, ~stamp};
endmodule

// ### sim/tb_adc_sample_sequence_timing.sv
/*
 * Self-checking bench of the converter sequence and timing block.
 * Assumes the time-stamp core model and the bound checker.
 */
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module tb_adc_sample_sequence_timing;
    import adc_seq_pkg::*;
    // ==========
    // Stimulus, observed outputs and bookkeeping.
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic [1:0] eventManagerTriggers = 2'h0;
    logic externalConversionStart = 1'h0;
    logic [15:0] regRdata, rd;
    logic sampleHold, sampleStrobe, busy, interrupt;
    core_sample_type coreSample;
    chan_select_type sampleChannel;
    int cyc = 0;
    int t0, badCount = 0, compares = 0;
    // Core stamp captured for a slot's result, counted from its trigger.
    localparam int LAT_A = `TRIG_DELAY_CYC + `RES_A_LAT_CYC;
    localparam int LAT_B = `TRIG_DELAY_CYC + `RES_B_LAT_CYC;

    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    adc_sample_sequence_timing u_adc_sample_sequence_timing
    (
        .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .eventManagerTriggers(eventManagerTriggers),
        .externalConversionStart(externalConversionStart),
        .coreSample(coreSample), .sampleHold(sampleHold),
        .sampleStrobe(sampleStrobe), .sampleChannel(sampleChannel),
        .busy(busy), .interrupt(interrupt)
    );
    adc_core_model u_adc_core_model
    (
        .ref_clk(ref_clk), .coreSample(coreSample)
    );

    // Comparisons count every call and report a mismatch at once.
    task check_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            badCount++;
            $display("unexpected at %0t: word %h not %h", $time, got, exp);
        end
    endtask
    task check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            badCount++;
            $display("unexpected at %0t: bit %b not %b", $time, got, exp);
        end
    endtask

    // Bus cycles; t0 keeps the cycle in which the last write stood.
    task reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        t0 = cyc + 1;
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge ref_clk);
        regWrite <= 1'h0;
    endtask
    task reg_read(input logic [7:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge ref_clk);
        regRead <= 1'h0;
        @(posedge ref_clk);
        rd = regRdata;
    endtask

    // Bounded wait for the sequence end, then room for the late flags.
    task wait_idle;
        int n;
        n = 0;
        @(posedge ref_clk);
        while (busy !== 1'h0 && n < 400)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 400)
        begin
            badCount++;
            $display("unexpected at %0t: sequencer stuck busy", $time);
        end
        repeat (6) @(posedge ref_clk);
    endtask

    task test_reset;
        reg_read(`REG_CTRL_ONE);
        check_word(rd, 16'h0000);
        reg_write(`REG_RESULT_A, 16'hffff);
        reg_read(`REG_RESULT_A);
        check_word(rd, 16'h0000);
        check_bit(interrupt, 1'h0);
        $display("test reset done");
    endtask

    task test_seq_single;
        reg_write(`REG_CHSEL, 16'h0005);
        reg_write(`REG_CTRL_ONE, 16'h0000);
        reg_write(`REG_CTRL_TWO, 16'h0001);
        wait_idle;
        reg_read(`REG_RESULT_A);
        check_word(rd, {4'h0, 12'(t0 + LAT_A)});
        reg_read(`REG_STATUS);
        check_word(rd, 16'h0003);
        check_bit(interrupt, 1'h0);
        $display("test sequential single done");
    endtask

    task test_seq_long;
        reg_write(`REG_STATUS, 16'h0007);
        reg_write(`REG_CTRL_ONE, 16'h2f00);
        reg_write(`REG_CTRL_TWO, 16'h0004);
        @(posedge ref_clk);
        t0 = cyc + 1;
        externalConversionStart <= 1'h1;
        @(posedge ref_clk);
        externalConversionStart <= 1'h0;
        wait_idle;
        reg_read(`REG_RESULT_A);
        check_word(rd, {4'h0, 12'(t0 + LAT_A + 2 * (2 + 15))});
        $display("test sequential long done");
    endtask

    task test_sim_pairs;
        reg_write(`REG_CTRL_TWO, 16'h0002);
        reg_write(`REG_CTRL_ONE, 16'h1108);
        for (int i = 0; i < 8; i++)
        begin
            reg_write(`REG_CHSEL, 16'(i));
            @(posedge ref_clk);
            t0 = cyc + 1;
            eventManagerTriggers <= i[0] ? 2'h2 : 2'h1;
            @(posedge ref_clk);
            eventManagerTriggers <= 2'h0;
            wait_idle;
            reg_read(`REG_RESULT_A);
            check_word(rd, {4'h0, 12'(t0 + LAT_A + 3 + 1)});
            reg_read(`REG_RESULT_B);
            check_word(rd, {4'h0, ~12'(t0 + LAT_B + 3 + 1)});
            check_word(16'(sampleChannel),
                {8'h00, 3'(i), 1'h1, 3'(i), 1'h1});
        end
        $display("test simultaneous pairs done");
    endtask

    task test_irq_overrun;
        int start;
        reg_write(`REG_MASK, 16'h0003);
        reg_write(`REG_STATUS, 16'h0007);
        reg_write(`REG_CTRL_ONE, 16'h1200);
        reg_write(`REG_CTRL_TWO, 16'h0001);
        start = t0;
        reg_write(`REG_CTRL_ONE, 16'h0000);
        reg_write(`REG_CTRL_TWO, 16'h0001);
        check_bit(interrupt, 1'h0);
        wait_idle;
        reg_read(`REG_RESULT_A);
        check_word(rd, {4'h0, 12'(start + LAT_A + 2 + 2)});
        check_bit(interrupt, 1'h1);
        reg_read(`REG_STATUS);
        check_word(rd, 16'h0007);
        reg_write(`REG_STATUS, 16'h0003);
        reg_read(`REG_STATUS);
        check_word(rd, 16'h0004);
        check_bit(interrupt, 1'h0);
        $display("test interrupt and overrun done");
    endtask

    // Continuous single-slot passes; the stop lands in the third slot's gap.
    task test_continuous;
        int start;
        reg_write(`REG_CTRL_ONE, 16'h0010);
        reg_write(`REG_CTRL_TWO, 16'h0001);
        start = t0;
        repeat (7) @(posedge ref_clk);
        check_bit(busy, 1'h1);
        reg_write(`REG_CTRL_TWO, 16'h0008);
        wait_idle;
        reg_read(`REG_RESULT_A);
        check_word(rd, {4'h0, 12'(start + LAT_A + 2 * 2)});
        $display("test continuous done");
    endtask

    task wrapUp;
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'h1;
        @(posedge ref_clk);
        test_reset;
        test_seq_single;
        test_seq_long;
        test_sim_pairs;
        test_continuous;
        test_irq_overrun;
        wrapUp;
    end

    // Watchdog well beyond the few hundred cycles the tests need.
    initial
    begin
        #(40 * 20000);
        badCount++;
        $display("unexpected at %0t: run did not finish", $time);
        wrapUp;
    end
endmodule
